// file: pkg/logger_mission_alarm_ctrl_defs.vh
// Purpose: shared constants of the mission and alarm register block
// Assumes: byte registers reached by their documented addresses
// Notes: offsets, field positions, reset values and log limits
`ifndef LOGGER_MISSION_ALARM_CTRL_DEFS_VH
`define LOGGER_MISSION_ALARM_CTRL_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define ADDR_LOW_THRESHOLD 16'h0208
`define ADDR_HIGH_THRESHOLD 16'h0209
`define ADDR_TEMP_ALARM_ENABLE 16'h0210
`define ADDR_CLOCK_CONTROL 16'h0212
`define ADDR_MISSION_CONFIG 16'h0213
`define ADDR_ALARM_FLAGS 16'h0214
`define ADDR_GENERAL_STATE 16'h0215

// ****************************************
// field positions
// ****************************************
`define BIT_LOW_ALARM_ENABLE 0
`define BIT_HIGH_ALARM_ENABLE 1
`define BIT_CRYSTAL_RUN 0
`define BIT_SECONDS_TIMEBASE 1
`define BIT_LOGGING_ENABLE 0
`define BIT_UNAVAILABLE_FUNC 1
`define BIT_WIDE_SAMPLE_FORMAT 2
`define BIT_WRAP_OVERWRITE_ENABLE 4
`define BIT_START_ON_ALARM 5
`define BIT_LOW_ALARM_FLAG 0
`define BIT_HIGH_ALARM_FLAG 1
`define BIT_BATTERY_RESET_FLAG 7
`define BIT_MISSION_ACTIVE 1
`define BIT_MEMORY_CLEARED 3
`define BIT_AWAITING_ALARM 4

// ****************************************
// fixed bits and reset values
// ****************************************
`define MISSION_CONFIG_FIXED 8'hC0
`define ALARM_FLAGS_FIXED 8'h70
`define GENERAL_STATE_FIXED 8'hC0
`define THRESHOLD_RESET 8'h00
`define UNMAPPED_READ 8'h00

// ****************************************
// log memory window
// ****************************************
`define LOG_FIRST_ADDR 16'h1000
`define LOG_LAST_ADDR 16'h2FFF

`endif

// file: verilog/threshold_check.v
// Purpose: one alarm threshold comparison on the result high byte
// Assumes: unsigned byte codes for sample and threshold
// Notes: purely combinational, instantiated once per alarm direction
`timescale 1ns/1ns
`default_nettype none

module threshold_check #(
    parameter ABOVE = 1
) (
    input wire [7:0] i_sample_msb,
    input wire [7:0] i_threshold,
    input wire i_enable,
    output wire o_hit
);

    // ****************************************
    // compare
    // ****************************************
    // equality counts as an alarm in both directions
    assign o_hit = i_enable &&
        ((ABOVE != 0) ? (i_sample_msb >= i_threshold) : (i_sample_msb <= i_threshold));

endmodule

`default_nettype wire

// file: verilog/logger_mission_alarm_ctrl.v
// Purpose: control and status registers, alarm flags and mission sequencing
// Assumes: command strobes, register strobes and conversions all on i_ref_clk
// Notes: i_rst is the battery-on reset; it leaves the battery reset flag set
`timescale 1ns/1ns
`default_nettype none

`include "logger_mission_alarm_ctrl_defs.vh"

// Functional notes
// - mission conversion at or above high threshold sets high flag if enabled
// - mission conversion at or below low threshold sets low flag if enabled
// - low threshold at 0208h, high threshold at 0209h drive the alarms
// - upper six bits of sensor and clock control read 0, ignore writes
// - control registers take no host writes while a mission runs
// - seconds_timebase picks seconds (1) or minutes (0) as interval unit
// - crystal_run 1 runs oscillator, 0 stops it into low-power retention
// - forced conversion or start mission sets crystal_run to 1
// - mission config bits 7,6 read 1; host writes bit 1 as 0, bit 3 ignored
// - start_on_alarm: 8-bit conversions, logging starts at alarm, no count
// - wrap enabled: full log memory restarts at log start, overwriting
// - wrap disabled: full memory stops conversions and logging, mission stays active
// - wide format stores 16-bit samples, high byte at lower address
// - logging needs logging_enable; samples stored from 1000h upward
// - alarm flags register read-only with fixed 1s and 0s
// - clear memory clears all alarm status flags together
// - general state register read-only with fixed bits and three flags
// - battery reset flag set after power-on reset, always enabled
// - forced conversion updates high and low flags like mission ones
// - alarm that starts logging also sets its alarm flag
// - conditional search answered while any alarm is held
// - only high byte of a result is compared with thresholds
// - awaiting_alarm cleared by alarm or by a start without start_on_alarm, kept over clear memory and stop
// - memory_cleared set by clear memory, dropped by start; start needs it
module logger_mission_alarm_ctrl (
    input wire i_ref_clk,
    input wire i_rst,
    input wire [15:0] i_reg_addr,
    input wire i_reg_wr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_rd,
    input wire i_cmd_force_conv,
    input wire i_cmd_start_mission,
    input wire i_cmd_stop_mission,
    input wire i_cmd_clear_memory,
    input wire i_second_pulse,
    input wire i_minute_pulse,
    input wire i_sample_due,
    input wire i_conv_done,
    input wire [15:0] i_conv_result,
    output reg [7:0] o_reg_rdata,
    output reg o_reg_rvalid,
    output reg o_crystal_run,
    output reg o_low_power,
    output reg o_interval_pulse,
    output reg o_conv_start,
    output reg o_conv_wide,
    output reg o_log_wr,
    output reg [15:0] o_log_addr,
    output reg [7:0] o_log_data,
    output reg o_mission_sample_inc,
    output reg o_mission_active,
    output reg o_alarm_search_hit
);

    // ****************************************
    // state encodings
    // ****************************************
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_WR_MSB = 3'b010;
    localparam [2:0] ST_WR_LSB = 3'b100;

    // ****************************************
    // registers
    // ****************************************
    reg [7:0] low_threshold_reg;
    reg [7:0] high_threshold_reg;
    reg high_alarm_enable_reg;
    reg low_alarm_enable_reg;
    reg crystal_run_reg;
    reg seconds_timebase_reg;
    reg start_on_alarm_reg;
    reg wrap_overwrite_enable_reg;
    reg wide_sample_format_reg;
    reg logging_enable_reg;
    reg high_alarm_flag_reg;
    reg low_alarm_flag_reg;
    reg battery_reset_flag_reg;
    reg awaiting_alarm_reg;
    reg memory_cleared_reg;
    reg mission_active_reg;
    reg log_stopped_reg;
    reg conv_forced_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [15:0] log_ptr_reg;
    reg [15:0] log_ptr_next;
    reg [7:0] sample_lsb_reg;
    reg log_stopped_next;

    wire high_hit;
    wire low_hit;
    wire any_hit;
    wire host_cfg_wr;
    wire start_ok;
    wire mission_conv;
    wire log_this;
    wire at_last;

    // ****************************************
    // alarm comparison
    // ****************************************
    // high byte only, whatever the log format
    threshold_check #(
        .ABOVE(1)
    ) u_high_check (
        .i_sample_msb(i_conv_result[15:8]),
        .i_threshold(high_threshold_reg),
        .i_enable(high_alarm_enable_reg),
        .o_hit(high_hit)
    );

    threshold_check #(
        .ABOVE(0)
    ) u_low_check (
        .i_sample_msb(i_conv_result[15:8]),
        .i_threshold(low_threshold_reg),
        .i_enable(low_alarm_enable_reg),
        .o_hit(low_hit)
    );

    // ****************************************
    // decode of events
    // ****************************************
    // control registers frozen during a mission
    assign host_cfg_wr = i_reg_wr && !mission_active_reg;
    assign any_hit = high_hit || low_hit;
    // start needs cleared memory and no running mission
    assign start_ok = i_cmd_start_mission && memory_cleared_reg && !mission_active_reg;
    assign mission_conv = i_conv_done && !conv_forced_reg && mission_active_reg;
    // alarming sample is logged when waiting, every sample otherwise
    assign log_this = mission_conv && logging_enable_reg && !log_stopped_reg &&
        (!awaiting_alarm_reg || any_hit);
    assign at_last = (log_ptr_reg == `LOG_LAST_ADDR);

    // ****************************************
    // host-written configuration
    // ****************************************
    // thresholds, enables, clock and mission options
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            low_threshold_reg <= `THRESHOLD_RESET;
            high_threshold_reg <= `THRESHOLD_RESET;
            high_alarm_enable_reg <= 1'b0;
            low_alarm_enable_reg <= 1'b0;
            seconds_timebase_reg <= 1'b0;
            start_on_alarm_reg <= 1'b0;
            wrap_overwrite_enable_reg <= 1'b0;
            wide_sample_format_reg <= 1'b0;
            logging_enable_reg <= 1'b0;
        end else if (host_cfg_wr) begin
            case (i_reg_addr)
                `ADDR_LOW_THRESHOLD: begin
                    low_threshold_reg <= i_reg_wdata;
                end
                `ADDR_HIGH_THRESHOLD: begin
                    high_threshold_reg <= i_reg_wdata;
                end
                `ADDR_TEMP_ALARM_ENABLE: begin
                    // bits 7..2 are not stored
                    high_alarm_enable_reg <= i_reg_wdata[`BIT_HIGH_ALARM_ENABLE];
                    low_alarm_enable_reg <= i_reg_wdata[`BIT_LOW_ALARM_ENABLE];
                end
                `ADDR_CLOCK_CONTROL: begin
                    seconds_timebase_reg <= i_reg_wdata[`BIT_SECONDS_TIMEBASE];
                end
                `ADDR_MISSION_CONFIG: begin
                    // bits 7,6 fixed; bit 3 and bit 1 not stored
                    start_on_alarm_reg <= i_reg_wdata[`BIT_START_ON_ALARM];
                    wrap_overwrite_enable_reg <= i_reg_wdata[`BIT_WRAP_OVERWRITE_ENABLE];
                    wide_sample_format_reg <= i_reg_wdata[`BIT_WIDE_SAMPLE_FORMAT];
                    logging_enable_reg <= i_reg_wdata[`BIT_LOGGING_ENABLE];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // oscillator enable
    // ****************************************
    // commands override a host write in the same cycle
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            crystal_run_reg <= 1'b0;
        end else if (i_cmd_force_conv || start_ok) begin
            crystal_run_reg <= 1'b1;
        end else if (host_cfg_wr && (i_reg_addr == `ADDR_CLOCK_CONTROL)) begin
            crystal_run_reg <= i_reg_wdata[`BIT_CRYSTAL_RUN];
        end
    end

    // ****************************************
    // alarm status flags
    // ****************************************
    // sticky; a hit in the clearing cycle wins
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            high_alarm_flag_reg <= 1'b0;
            low_alarm_flag_reg <= 1'b0;
            battery_reset_flag_reg <= 1'b1;
        end else begin
            if (i_cmd_clear_memory && !mission_active_reg) begin
                high_alarm_flag_reg <= 1'b0;
                low_alarm_flag_reg <= 1'b0;
                battery_reset_flag_reg <= 1'b0;
            end
            // mission and forced conversions both reach the flags
            if (i_conv_done && (conv_forced_reg || mission_active_reg)) begin
                if (high_hit) begin
                    high_alarm_flag_reg <= 1'b1;
                end
                if (low_hit) begin
                    low_alarm_flag_reg <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // mission status
    // ****************************************
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            mission_active_reg <= 1'b0;
            memory_cleared_reg <= 1'b0;
            awaiting_alarm_reg <= 1'b0;
        end else begin
            if (start_ok) begin
                mission_active_reg <= 1'b1;
                memory_cleared_reg <= 1'b0;
                awaiting_alarm_reg <= start_on_alarm_reg;
            end else begin
                if (i_cmd_stop_mission) begin
                    mission_active_reg <= 1'b0;
                end
                if (i_cmd_clear_memory && !mission_active_reg) begin
                    memory_cleared_reg <= 1'b1;
                end
                // alarm only; clear memory and stop leave it
                if (i_conv_done && any_hit && (conv_forced_reg || mission_active_reg)) begin
                    awaiting_alarm_reg <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // conversion requests
    // ****************************************
    // mission samples until memory stops them; forced ones only while no mission runs
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_conv_start <= 1'b0;
            o_conv_wide <= 1'b0;
            conv_forced_reg <= 1'b0;
        end else begin
            o_conv_start <= 1'b0;
            if (i_cmd_force_conv && !mission_active_reg) begin
                o_conv_start <= 1'b1;
                o_conv_wide <= wide_sample_format_reg;
                conv_forced_reg <= 1'b1;
            end else if (i_sample_due && mission_active_reg && !log_stopped_reg) begin
                o_conv_start <= 1'b1;
                // 8-bit while waiting for the trigger alarm
                o_conv_wide <= wide_sample_format_reg && !awaiting_alarm_reg;
                conv_forced_reg <= 1'b0;
            end else if (i_conv_done) begin
                conv_forced_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // log write sequencing
    // ****************************************
    // next state, pointer and stop of the log
    always @* begin
        state_next = state_reg;
        log_ptr_next = log_ptr_reg;
        log_stopped_next = log_stopped_reg;
        case (state_reg)
            ST_IDLE: begin
                if (log_this) begin
                    state_next = ST_WR_MSB;
                end
            end
            ST_WR_MSB: begin
                state_next = wide_sample_format_reg ? ST_WR_LSB : ST_IDLE;
            end
            ST_WR_LSB: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // advance after every byte written, held at the last address when wrap is disabled
        if (o_log_wr) begin
            if (at_last) begin
                if (wrap_overwrite_enable_reg) begin
                    log_ptr_next = `LOG_FIRST_ADDR;
                end else begin
                    log_ptr_next = log_ptr_reg;
                    log_stopped_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end else begin
                log_ptr_next = log_ptr_reg + 16'h0001;
            end
        end
        if (start_ok) begin
            log_ptr_next = `LOG_FIRST_ADDR;
            log_stopped_next = 1'b0;
        end
    end

    // byte writes, high byte first at the lower address
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            log_ptr_reg <= `LOG_FIRST_ADDR;
            log_stopped_reg <= 1'b0;
            sample_lsb_reg <= 8'h00;
            o_log_wr <= 1'b0;
            o_log_addr <= `LOG_FIRST_ADDR;
            o_log_data <= 8'h00;
        end else begin
            state_reg <= state_next;
            log_ptr_reg <= log_ptr_next;
            log_stopped_reg <= log_stopped_next;
            o_log_wr <= 1'b0;
            if (state_reg == ST_IDLE && log_this) begin
                sample_lsb_reg <= i_conv_result[7:0];
                o_log_data <= i_conv_result[15:8];
                o_log_addr <= log_ptr_reg;
                o_log_wr <= 1'b1;
            end else if (state_next == ST_WR_LSB && state_reg == ST_WR_MSB) begin
                o_log_data <= sample_lsb_reg;
                o_log_addr <= log_ptr_next;
                o_log_wr <= 1'b1;
            end
        end
    end

    // ****************************************
    // mission sample count
    // ****************************************
    // the sample that ends the wait is not counted
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_mission_sample_inc <= 1'b0;
        end else begin
            o_mission_sample_inc <= mission_conv && !log_stopped_reg && !awaiting_alarm_reg;
        end
    end

    // ****************************************
    // timebase and status outputs
    // ****************************************
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_interval_pulse <= 1'b0;
            o_crystal_run <= 1'b0;
            o_low_power <= 1'b1;
            o_mission_active <= 1'b0;
            o_alarm_search_hit <= 1'b0;
        end else begin
            // interval unit from the selected timebase
            o_interval_pulse <= crystal_run_reg &&
                (seconds_timebase_reg ? i_second_pulse : i_minute_pulse);
            o_crystal_run <= crystal_run_reg;
            o_low_power <= !crystal_run_reg;
            o_mission_active <= mission_active_reg;
            o_alarm_search_hit <= high_alarm_flag_reg || low_alarm_flag_reg ||
                battery_reset_flag_reg;
        end
    end

    // ****************************************
    // register read
    // ****************************************
    // data one cycle after the read strobe
    always @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_reg_rdata <= `UNMAPPED_READ;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `ADDR_LOW_THRESHOLD: begin
                        o_reg_rdata <= low_threshold_reg;
                    end
                    `ADDR_HIGH_THRESHOLD: begin
                        o_reg_rdata <= high_threshold_reg;
                    end
                    `ADDR_TEMP_ALARM_ENABLE: begin
                        o_reg_rdata <= {6'h00, high_alarm_enable_reg,
                            low_alarm_enable_reg};
                    end
                    `ADDR_CLOCK_CONTROL: begin
                        o_reg_rdata <= {6'h00, seconds_timebase_reg, crystal_run_reg};
                    end
                    `ADDR_MISSION_CONFIG: begin
                        o_reg_rdata <= `MISSION_CONFIG_FIXED |
                            {2'b00, start_on_alarm_reg, wrap_overwrite_enable_reg, 1'b0,
                            wide_sample_format_reg, 1'b0, logging_enable_reg};
                    end
                    `ADDR_ALARM_FLAGS: begin
                        o_reg_rdata <= `ALARM_FLAGS_FIXED |
                            {battery_reset_flag_reg, 5'h00, high_alarm_flag_reg,
                            low_alarm_flag_reg};
                    end
                    `ADDR_GENERAL_STATE: begin
                        o_reg_rdata <= `GENERAL_STATE_FIXED |
                            {3'b000, awaiting_alarm_reg, memory_cleared_reg, 1'b0,
                            mission_active_reg, 1'b0};
                    end
                    default: begin
                        o_reg_rdata <= `UNMAPPED_READ;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// file: sim/conv_sensor_model.sv
// Purpose: sensor side model answering conversion requests
// Assumes: one request at a time, same clock as the block
// Notes: result bus toggles whenever no answer is being given
`timescale 1ns/1ns
`default_nettype none
module conv_sensor_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [15:0] i_temp,
    output logic o_done,
    output logic [15:0] o_result
);
    logic [2:0] cnt_reg;
    // answer four cycles after a request, keeping done pulses apart
    always @(posedge i_clk) begin
        o_done <= 1'h0;
        o_result <= ~o_result;
        if (i_rst) begin
            cnt_reg <= 3'h0;
            o_result <= 16'hA5A5;
        end else if (i_start) begin
            cnt_reg <= 3'h4;
        end else if (cnt_reg != 3'h0) begin
            cnt_reg <= cnt_reg - 3'h1;
            o_done <= (cnt_reg == 3'h1);
            if (cnt_reg == 3'h1) o_result <= i_temp;
        end
    end
endmodule
`default_nettype wire

// file: sim/logger_mission_alarm_ctrl_monitor.sv
// Purpose: port-level checks of the mission and alarm register block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to every instance of the block
`timescale 1ns/1ns
`default_nettype none
module logger_mission_alarm_ctrl_monitor (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_cmd_force_conv,
    input wire logic i_cmd_stop_mission,
    input wire logic i_second_pulse,
    input wire logic i_minute_pulse,
    input wire logic i_sample_due,
    input wire logic o_conv_start,
    input wire logic o_interval_pulse,
    input wire logic o_crystal_run,
    input wire logic o_low_power,
    input wire logic o_log_wr,
    input wire logic [15:0] o_log_addr,
    input wire logic o_mission_active,
    input wire logic o_alarm_search_hit
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // two log bytes back to back
    sequence two_log_bytes;
        o_log_wr ##1 o_log_wr;
    endsequence
    chk_osc_power_inverse: assert property (o_low_power == !o_crystal_run)
        else $error("low power is not the inverse of oscillator run");
    chk_force_runs_osc: assert property (i_cmd_force_conv |-> ##2 o_crystal_run)
        else $error("forced conversion left oscillator stopped");
    chk_tick_cause: assert property (o_interval_pulse |-> $past(i_second_pulse) || $past(i_minute_pulse))
        else $error("interval tick without a timebase tick");
    chk_log_window: assert property (o_log_wr |-> o_log_addr >= 16'h1000 && o_log_addr <= 16'h2FFF)
        else $error("log write outside log memory");
    chk_byte_pair: assert property (two_log_bytes |-> o_log_addr == $past(o_log_addr) + 16'h1 || o_log_addr == 16'h1000)
        else $error("second log byte not at next address");
    chk_search_boot: assert property ($fell(i_rst) |-> ##[1:2] o_alarm_search_hit)
        else $error("battery flag not raised after reset");
    chk_stop_cause: assert property ($fell(o_mission_active) |-> $past(i_cmd_stop_mission, 2))
        else $error("mission ended without stop command");
    chk_conv_cause: assert property (o_conv_start |-> $past(i_sample_due) || $past(i_cmd_force_conv))
        else $error("conversion started without a cause");
endmodule
bind logger_mission_alarm_ctrl logger_mission_alarm_ctrl_monitor u_mon (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cmd_force_conv(i_cmd_force_conv),
    .i_cmd_stop_mission(i_cmd_stop_mission), .i_second_pulse(i_second_pulse),
    .i_minute_pulse(i_minute_pulse), .i_sample_due(i_sample_due), .o_conv_start(o_conv_start),
    .o_interval_pulse(o_interval_pulse), .o_crystal_run(o_crystal_run),
    .o_low_power(o_low_power), .o_log_wr(o_log_wr), .o_log_addr(o_log_addr),
    .o_mission_active(o_mission_active), .o_alarm_search_hit(o_alarm_search_hit));
`default_nettype wire

// file: sim/tb_logger_mission_alarm_ctrl.sv
// Purpose: self-checking bench of the mission and alarm register block
// Assumes: inputs move 1 ns after the rising edge
// Notes: conversions are answered by the sensor model
`timescale 1ns/1ns
`default_nettype none
module tb_logger_mission_alarm_ctrl;
    logic clk = 1'h0, rst = 1'h1, rd = 1'h0, wr = 1'h0, sp = 1'h0, mp = 1'h0, sd = 1'h0;
    logic [3:0] cmd = 4'h0;
    logic [15:0] addr = 16'h0000, temp = 16'h0000;
    logic [7:0] wdata = 8'h00;
    wire [7:0] rdata, log_data;
    wire [15:0] log_addr, res;
    wire rvalid, osc, lp, tick, go, done, log_wr, active, hit, wide, inc;
    integer n_errors = 0, check_count = 0, cyc = 0, n_log = 0, n_inc = 0;
    logic [23:0] log_q [0:7];
    logger_mission_alarm_ctrl uut (.i_ref_clk(clk), .i_rst(rst), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_wdata(wdata), .i_reg_rd(rd), .i_cmd_force_conv(cmd[0]),
        .i_cmd_start_mission(cmd[1]), .i_cmd_stop_mission(cmd[2]),
        .i_cmd_clear_memory(cmd[3]), .i_second_pulse(sp), .i_minute_pulse(mp),
        .i_sample_due(sd), .i_conv_done(done), .i_conv_result(res), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .o_crystal_run(osc), .o_low_power(lp), .o_interval_pulse(tick),
        .o_conv_start(go), .o_conv_wide(wide), .o_log_wr(log_wr), .o_log_addr(log_addr),
        .o_log_data(log_data), .o_mission_sample_inc(inc), .o_mission_active(active),
        .o_alarm_search_hit(hit));
    conv_sensor_model u_sensor (.i_clk(clk), .i_rst(rst), .i_start(go), .i_temp(temp),
        .o_done(done), .o_result(res));
    // clock, log capture and hang limit
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        n_inc <= n_inc + inc;
        if (log_wr === 1'h1) begin
            log_q[n_log] <= {log_addr, log_data};
            n_log <= n_log + 1;
        end
        if (cyc == 3000) begin
            n_errors = n_errors + 1;
            test_done;
        end
    end
    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task ck(input [23:0] e, input [23:0] s, input [63:0] nm);
        check_count = check_count + 1;
        if (e !== s) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, s);
        end
    endtask
    task step;
        @(posedge clk);
        #1;
    endtask
    task wreg(input [15:0] a, input [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'h1;
        step;
        wr = 1'h0;
        step;
    endtask
    task rreg(input [15:0] a, input [7:0] e, input [63:0] nm);
        addr = a;
        rd = 1'h1;
        step;
        rd = 1'h0;
        ck({1'h1, e}, {rvalid, rdata}, nm);
        step;
    endtask
    task pulse(input [3:0] c);
        cmd = c;
        step;
        cmd = 4'h0;
        step;
    endtask
    task conv(input [15:0] t, input f);
        temp = t;
        if (f) cmd = 4'h1;
        else sd = 1'h1;
        step;
        cmd = 4'h0;
        sd = 1'h0;
        repeat (12) if (done !== 1'h1) step;
        repeat (3) step;
    endtask
    task t_reset;
        rreg(16'h0214, 8'hF0, "alarm");
        rreg(16'h0215, 8'hC0, "general");
        rreg(16'h0300, 8'h00, "unmapped");
        ck(1'h1, hit, "search");
        $display("t_reset done");
    endtask
    task t_fields;
        wreg(16'h0210, 8'hFF);
        rreg(16'h0210, 8'h03, "sensor");
        wreg(16'h0212, 8'hFF);
        rreg(16'h0212, 8'h03, "clock");
        sp = 1'h1;
        step;
        sp = 1'h0;
        mp = 1'h1;
        ck(1'h1, tick, "sec tick");
        step;
        mp = 1'h0;
        ck(1'h0, tick, "min tick");
        wreg(16'h0212, 8'h02);
        ck(2'h1, {osc, lp}, "lowpwr");
        wreg(16'h0213, 8'hFD);
        rreg(16'h0213, 8'hF5, "mission");
        wreg(16'h0214, 8'h00);
        rreg(16'h0214, 8'hF0, "ro flags");
        $display("t_fields done");
    endtask
    task t_force;
        wreg(16'h0208, 8'hFF);
        wreg(16'h0209, 8'h50);
        wreg(16'h0210, 8'h02);
        conv(16'h50FF, 1'h1);
        ck(1'h1, osc, "osc");
        rreg(16'h0214, 8'hF2, "force hi");
        pulse(4'h8);
        rreg(16'h0214, 8'h70, "cleared");
        rreg(16'h0215, 8'hC8, "memory_cleared");
        $display("t_force done");
    endtask
    task t_mission;
        wreg(16'h0208, 8'h20);
        wreg(16'h0209, 8'hF0);
        wreg(16'h0210, 8'h03);
        wreg(16'h0213, 8'h05);
        pulse(4'h2);
        step;
        ck(1'h1, active, "active");
        rreg(16'h0215, 8'hC2, "mip");
        wreg(16'h0210, 8'h00);
        rreg(16'h0210, 8'h03, "locked");
        conv(16'h1ABC, 1'h0);
        conv(16'h3000, 1'h0);
        rreg(16'h0214, 8'h71, "low");
        ck({16'h1000, 8'h1A}, log_q[0], "log0");
        ck({16'h1001, 8'hBC}, log_q[1], "log1");
        ck(24'h4, n_log, "nlog");
        ck(24'h2, n_inc, "ninc");
        ck(1'h1, wide, "wide");
        pulse(4'h4);
        step;
        ck(1'h0, active, "stop");
        $display("t_mission done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1 rst = 1'h0;
        step;
        t_reset;
        t_fields;
        t_force;
        t_mission;
        test_done;
    end
endmodule
`default_nettype wire
